// [rtl/pfm_fault_core.sv]
// Fault input mode sequencer and output override for the PWM timer
module pfm_fault_core
  import pfm_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  enable,
  input  wire logic [PFM_MODE_W-1:0] fault_mode_select,
  input  wire logic                  restart_cmd,
  input  wire pfm_times_t            times,
  input  wire pfm_ev_t               ev,
  output      logic                  wave_out_a,
  output      logic                  wave_out_b,
  output      pfm_phase_t            phase,
  output      logic                  stalled
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pfm_phase_t  phase;
    pfm_ev_t     ev_s;      // Registered events, first pipeline stage
    pfm_ev_t     ev_p;      // Previous events for edge detection
    logic        blk_a;     // Output A blocked to end of on time
    logic        blk_b;
    logic        stall;
    logic        rep;       // Mode 2/3 other-cycle run active
    logic        rep_a;     // Fault source of repeat is A
    logic        halt;      // Mode 7 halt
    logic        wave_a;
    logic        wave_b;
    logic        stl;       // Registered stall or halt flag for the port
  } pfm_st_t;

  pfm_st_t st_ff;
  pfm_st_t nxt_st;
  logic    ph_done;
  logic    ph_load;
  logic [PFM_CNT_W-1:0] ph_len;

  // Next phase in the normal cycle
  function automatic pfm_phase_t next_phase(input pfm_phase_t p);
    unique case (p)
      PFM_DEAD_A: next_phase = PFM_ON_A;
      PFM_ON_A:   next_phase = PFM_DEAD_B;
      PFM_DEAD_B: next_phase = PFM_ON_B;
      default:    next_phase = PFM_DEAD_A;
    endcase
  endfunction : next_phase

  // True in a phase belonging to channel A
  function automatic logic in_a(input pfm_phase_t p);
    in_a = (p == PFM_DEAD_A) || (p == PFM_ON_A);
  endfunction : in_a

  // ****************************************
  // Phase length
  // ****************************************
  always_comb
  begin
    unique case (st_ff.phase)
      PFM_DEAD_A: ph_len = times.dead_a;
      PFM_ON_A:   ph_len = times.on_a;
      PFM_DEAD_B: ph_len = times.dead_b;
      default:    ph_len = times.on_b;
    endcase
  end

  pfm_phase_cnt #(
    .CNT_W (PFM_CNT_W)
  ) u_cnt (
    .clk    (clk),
    .arst_n (arst_n),
    .run    (enable && !st_ff.stall && !st_ff.halt),
    .load   (ph_load),
    .len    (ph_len),
    .done   (ph_done)
  );

  assign ph_load = (nxt_st.phase != st_ff.phase) || !enable;

  // ****************************************
  // Sequencer and override
  // ****************************************
  always_comb
  begin
    logic       fa;
    logic       fb;
    logic       fany;
    logic       ra;
    logic       rb;
    logic       own;
    logic       on_ph;
    pfm_phase_t np;
    fa    = 1'b0;
    fb    = 1'b0;
    fany  = 1'b0;
    ra    = 1'b0;
    rb    = 1'b0;
    own   = 1'b0;
    on_ph = 1'b0;
    np    = PFM_DEAD_A;
    nxt_st = st_ff;
    nxt_st.ev_s = ev;
    nxt_st.ev_p = st_ff.ev_s;
    fa    = st_ff.ev_s.ev_a;
    fb    = st_ff.ev_s.ev_b;
    fany  = fa || fb;
    ra    = fa && !st_ff.ev_p.ev_a;
    rb    = fb && !st_ff.ev_p.ev_b;
    own   = in_a(st_ff.phase) ? fa : fb;
    on_ph = (st_ff.phase == PFM_ON_A) || (st_ff.phase == PFM_ON_B);
    np    = next_phase(st_ff.phase);
    if (ph_done)
    begin
      nxt_st.phase = np;
      nxt_st.blk_a = 1'b0;
      nxt_st.blk_b = 1'b0;
    end
    if (!enable)
    begin
      nxt_st.phase = PFM_DEAD_A;
      nxt_st.stall = 1'b0;
      nxt_st.rep   = 1'b0;
      nxt_st.halt  = 1'b0;
    end
    else
    begin
      unique case (fault_mode_select)
        PFM_M_JUMP:
          if (own && !st_ff.stall)
          begin
            nxt_st.phase = in_a(st_ff.phase) ? PFM_DEAD_B : PFM_DEAD_A;
            nxt_st.stall = 1'b1;
            nxt_st.rep_a = in_a(st_ff.phase);
          end
          else if (st_ff.stall && !(st_ff.rep_a ? fa : fb))
            nxt_st.stall = 1'b0;
        PFM_M_OTHER, PFM_M_REPEAT:
        begin
          if (!st_ff.rep && !st_ff.stall && own)
          begin
            nxt_st.rep   = 1'b1;
            nxt_st.rep_a = in_a(st_ff.phase);
            nxt_st.phase = in_a(st_ff.phase) ? PFM_DEAD_B : PFM_DEAD_A;
          end
          else if (st_ff.rep && ph_done && on_ph)
          begin
            // Other cycle done: go back to the other channel's dead time to repeat it
            nxt_st.phase = st_ff.rep_a ? PFM_DEAD_B : PFM_DEAD_A;
            if (!(st_ff.rep_a ? fa : fb))
            begin
              nxt_st.rep   = 1'b0;
              nxt_st.phase = np;
            end
            else if (fault_mode_select == PFM_M_OTHER)
            begin
              nxt_st.stall = 1'b1;
              nxt_st.rep   = 1'b0;
              nxt_st.phase = np;
            end
          end
          if (st_ff.stall && !(st_ff.rep_a ? fa : fb))
            nxt_st.stall = 1'b0;
        end
        PFM_M_DEADONL:
          if (fany && on_ph)
            nxt_st.phase = (st_ff.phase == PFM_ON_A) ? PFM_DEAD_B : PFM_DEAD_A;
          else if (fany && ph_done)
            nxt_st.phase = (st_ff.phase == PFM_DEAD_A) ? PFM_DEAD_B : PFM_DEAD_A;
        PFM_M_WAIT:
          if (st_ff.stall)
          begin
            if (!fany)
            begin
              nxt_st.stall = 1'b0;
              nxt_st.phase = (st_ff.phase == PFM_DEAD_A) ? PFM_DEAD_B : PFM_DEAD_A;
            end
          end
          else if (fany && on_ph)
          begin
            nxt_st.phase = (st_ff.phase == PFM_ON_A) ? PFM_DEAD_B : PFM_DEAD_A;
            nxt_st.stall = 1'b1;
          end
          else if (fany && ph_done)
          begin
            nxt_st.phase = st_ff.phase;
            nxt_st.stall = 1'b1;
          end
        PFM_M_SWSTOP:
          if (restart_cmd)
          begin
            nxt_st.halt  = fany;
            nxt_st.phase = PFM_DEAD_A;
          end
          else if (fany)
            nxt_st.halt = 1'b1;
        PFM_M_EDGEJ:
          if ((ra && st_ff.phase == PFM_ON_A) || (rb && st_ff.phase == PFM_ON_B))
            nxt_st.phase = (st_ff.phase == PFM_ON_A) ? PFM_DEAD_B : PFM_DEAD_A;
        PFM_M_EDGEB:
        begin
          if (ra && st_ff.phase == PFM_ON_A && !ph_done)
            nxt_st.blk_a = 1'b1;
          if (rb && st_ff.phase == PFM_ON_B && !ph_done)
            nxt_st.blk_b = 1'b1;
        end
        PFM_M_LEVEL:
        begin
          if (fa && st_ff.phase == PFM_ON_A && !ph_done)
            nxt_st.blk_a = 1'b1;
          if (fb && st_ff.phase == PFM_ON_B && !ph_done)
            nxt_st.blk_b = 1'b1;
        end
        default:
        begin
          nxt_st.stall = 1'b0;
          nxt_st.rep   = 1'b0;
          nxt_st.halt  = 1'b0;
        end
      endcase
    end
    // Output gating from the next phase
    nxt_st.wave_a = enable && (nxt_st.phase == PFM_ON_A) && !nxt_st.blk_a
                    && !nxt_st.halt;
    nxt_st.wave_b = enable && (nxt_st.phase == PFM_ON_B) && !nxt_st.blk_b
                    && !nxt_st.halt;
    if (enable)
    begin
      unique case (fault_mode_select)
        PFM_M_KILL, PFM_M_DEADONL, PFM_M_WAIT, PFM_M_SWSTOP:
        begin
          if (fany)
          begin
            nxt_st.wave_a = 1'b0;
            nxt_st.wave_b = 1'b0;
          end
        end
        PFM_M_LEVEL:
        begin
          if (fa)
            nxt_st.wave_a = 1'b0;
          if (fb)
            nxt_st.wave_b = 1'b0;
        end
        PFM_M_JUMP, PFM_M_OTHER, PFM_M_REPEAT:
        begin
          if (fa && in_a(st_ff.phase))
            nxt_st.wave_a = 1'b0;
          if (fb && !in_a(st_ff.phase))
            nxt_st.wave_b = 1'b0;
        end
        default:
        begin
          nxt_st.wave_a = nxt_st.wave_a;
        end
      endcase
    end
    // Stall flag leaves the block straight from a flop
    nxt_st.stl = nxt_st.stall || nxt_st.halt;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff       <= '0;
      st_ff.phase <= PFM_DEAD_A;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wave_out_a = st_ff.wave_a;
  assign wave_out_b = st_ff.wave_b;
  assign phase      = st_ff.phase;
  assign stalled    = st_ff.stl;

endmodule : pfm_fault_core

// [rtl/pfm_pkg.sv]
// Package of constants and types for the PWM fault input mode block
package pfm_pkg;

  // ****************************************
  // Widths and constants
  // ****************************************
  localparam int          PFM_CNT_W    = 12;
  localparam int          PFM_MODE_W   = 4;
  localparam logic [11:0] PFM_CNT_ZERO = 12'h000;
  localparam logic [11:0] PFM_CNT_ONE  = 12'h001;

  localparam logic [3:0] PFM_M_NONE    = 4'h0;
  localparam logic [3:0] PFM_M_JUMP    = 4'h1;
  localparam logic [3:0] PFM_M_OTHER   = 4'h2;
  localparam logic [3:0] PFM_M_REPEAT  = 4'h3;
  localparam logic [3:0] PFM_M_KILL    = 4'h4;
  localparam logic [3:0] PFM_M_DEADONL = 4'h5;
  localparam logic [3:0] PFM_M_WAIT    = 4'h6;
  localparam logic [3:0] PFM_M_SWSTOP  = 4'h7;
  localparam logic [3:0] PFM_M_EDGEJ   = 4'h8;
  localparam logic [3:0] PFM_M_EDGEB   = 4'h9;
  localparam logic [3:0] PFM_M_LEVEL   = 4'ha;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    PFM_DEAD_A = 4'b0001,
    PFM_ON_A   = 4'b0010,
    PFM_DEAD_B = 4'b0100,
    PFM_ON_B   = 4'b1000
  } pfm_phase_t;

  // Phase lengths in counter ticks
  typedef struct packed {
    logic [11:0] dead_a;
    logic [11:0] on_a;
    logic [11:0] dead_b;
    logic [11:0] on_b;
  } pfm_times_t;

  // Fault event inputs
  typedef struct packed {
    logic ev_a;
    logic ev_b;
  } pfm_ev_t;

endpackage : pfm_pkg

// [rtl/pfm_phase_cnt.sv]
// Phase length counter with stall and reload
module pfm_phase_cnt
  import pfm_pkg::*;
#(
  parameter int CNT_W = PFM_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] len,
  output      logic             done
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } pfm_cnt_st_t;

  pfm_cnt_st_t st_ff;
  pfm_cnt_st_t nxt_st;

  // Done when the phase has counted its length
  assign done = run && (st_ff.cnt >= len);

  // Count while running, reload on phase change
  always_comb
  begin
    nxt_st = st_ff;
    if (load)
      nxt_st.cnt = CNT_W'(PFM_CNT_ZERO);
    else if (run)
      nxt_st.cnt = st_ff.cnt + CNT_W'(PFM_CNT_ONE);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

endmodule : pfm_phase_cnt

// [tb/pfm_fault_chk.sv]
// Port checker of the fault mode block
module pfm_fault_chk
  import pfm_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  enable,
  input wire logic [PFM_MODE_W-1:0] fault_mode_select,
  input wire logic                  restart_cmd,
  input wire pfm_times_t            times,
  input wire pfm_ev_t               ev,
  input wire logic                  wave_out_a,
  input wire logic                  wave_out_b,
  input wire pfm_phase_t            phase,
  input wire logic                  stalled
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Modes that leave the counter running free
  wire logic free = enable && (fault_mode_select inside {PFM_M_NONE, PFM_M_KILL,
                    PFM_M_EDGEB, PFM_M_LEVEL} || fault_mode_select > PFM_M_LEVEL);
  wire logic any_ev = ev.ev_a || ev.ev_b;

  chk_a_gate: assert property (wave_out_a |-> phase == PFM_ON_A)
    else $error("output a high outside its on phase");
  chk_b_gate: assert property (wave_out_b |-> phase == PFM_ON_B)
    else $error("output b high outside its on phase");
  chk_kill_outs: assert property ((enable && fault_mode_select == PFM_M_KILL && any_ev)[*3]
    |-> !wave_out_a && !wave_out_b) else $error("kill mode left an output on");
  chk_free_run: assert property (free[*3] |-> !stalled)
    else $error("counter stalled in a free mode");
  chk_free_order: assert property (free ##1 (free && $changed(phase))
    |-> phase == {$past(phase[2:0]), $past(phase[3])}) else $error("phase out of order");
  chk_stall_outs: assert property (stalled |-> !wave_out_a && !wave_out_b)
    else $error("output on while stalled");
  chk_stall_hold: assert property ((stalled && enable && !restart_cmd && !$past(restart_cmd))
    ##1 (stalled && enable) |-> $stable(phase))
    else $error("phase moved while stalled");
  chk_level_block: assert property ((enable && fault_mode_select == PFM_M_LEVEL && ev.ev_a)[*3]
    |-> !wave_out_a) else $error("level mode left output a on");
  chk_sw_halt: assert property ((enable && fault_mode_select == PFM_M_SWSTOP && any_ev)[*3]
    |-> stalled) else $error("halt mode did not stop");
  chk_idle_off: assert property (!enable ##1 !enable
    |-> phase == PFM_DEAD_A && !stalled && !wave_out_a && !wave_out_b)
    else $error("disabled timer not idle");

  // Main scenarios
  cov_stall: cover property (stalled);
  cov_kill: cover property (enable && fault_mode_select == PFM_M_KILL && ev.ev_a);
  cov_restart: cover property (restart_cmd && stalled);
endmodule : pfm_fault_chk

bind pfm_fault_core pfm_fault_chk u_chk (.clk(clk), .arst_n(arst_n), .enable(enable),
  .fault_mode_select(fault_mode_select), .restart_cmd(restart_cmd), .times(times), .ev(ev),
  .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .phase(phase), .stalled(stalled));

// [tb/pfm_ev_net.sv]
// Event routing network model delivering fault levels promptly or one cycle late
module pfm_ev_net
  import pfm_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    arst_n,
  input  wire logic    slow,
  input  wire pfm_ev_t req,
  output      pfm_ev_t ev
);
  pfm_ev_t dly_ff;

  // Delay stage for the slow route
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      dly_ff <= '0;
    else
      dly_ff <= req;

  assign ev = slow ? dly_ff : req;
endmodule : pfm_ev_net

// [tb/pwm_fault_input_modes_test.sv]
// Testbench of the fault mode block
module pwm_fault_input_modes_test
  import pfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam pfm_ev_t EVA = 2'b10;
  logic        clk = 0, arst_n = 0, enable = 0, restart_cmd = 0, slow = 0;
  logic [3:0]  mode_sel = 4'h0;
  pfm_times_t  times = '0;
  pfm_ev_t     req = '0, ev;
  logic        wa, wb, stalled;
  pfm_phase_t  phase, last_ph = PFM_DEAD_A;
  int          err_count = 0, n_checks = 0, run_len = 0;
  bit          model_ok = 0;
  logic [31:0] lfsr = 32'hf2b7_88c1;
  logic [3:0]  fm [5] = '{4'h0, 4'h4, 4'h9, 4'ha, 4'hd};

  always #10 clk = ~clk;

  pfm_ev_net u_net (.clk(clk), .arst_n(arst_n), .slow(slow), .req(req), .ev(ev));
  pfm_fault_core DUT (.clk(clk), .arst_n(arst_n), .enable(enable), .fault_mode_select(mode_sel),
    .restart_cmd(restart_cmd), .times(times), .ev(ev), .wave_out_a(wa), .wave_out_b(wb),
    .phase(phase), .stalled(stalled));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic bit free_mode(input logic [3:0] m);
    free_mode = m inside {4'h0, 4'h4, 4'h9, 4'ha} || m > 4'ha;
  endfunction : free_mode

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Times and mode only change while the timer is off
  task automatic setup(input logic [3:0] m, input bit rnd);
    @(negedge clk);
    enable = 0;
    req = '0;
    repeat (2) @(negedge clk);
    mode_sel = m;
    lfsr = lfsr_next(lfsr);
    times = rnd ? {12'(lfsr[2:0]), 12'(lfsr[5:3]), 12'(lfsr[8:6]), 12'(lfsr[11:9])}
                : {4{12'h005}};
    @(negedge clk);
    enable = 1;
  endtask : setup

  task automatic wait_ph(input pfm_phase_t p);
    int k;
    k = 0;
    while (phase === p && k < 50) begin @(negedge clk); k++; end
    while (phase !== p && k < 100) begin @(negedge clk); k++; end
    check(12'(k < 100), 12'h001);
  endtask : wait_ph

  task automatic pulse();
    restart_cmd = 1;
    @(negedge clk);
    restart_cmd = 0;
  endtask : pulse

  // Event at the first cycle of a phase, then phase and stall before release and phase after it
  task automatic scen(input logic [3:0] m, input pfm_ev_t e, input pfm_phase_t tp,
                      input int d, input logic [3:0] xp, input logic xs, input logic [3:0] rp);
    setup(m, 0);
    wait_ph(tp);
    req = e;
    repeat (d) @(negedge clk);
    if (xp != 0) check(12'(phase), 12'(xp));
    check(12'(stalled), 12'(xs));
    req = '0;
    repeat (4) @(negedge clk);
    if (rp != 0) check(12'(phase), 12'(rp));
  endtask : scen

  // ****
  // Phase model of the free running modes
  // ****
  always @(negedge clk)
  begin
    if (!enable || !free_mode(mode_sel)) model_ok = 0;
    if (phase !== last_ph)
    begin
      if (model_ok)
      begin
        check(12'(run_len), (last_ph == PFM_DEAD_A ? times.dead_a : last_ph == PFM_ON_A ?
              times.on_a : last_ph == PFM_DEAD_B ? times.dead_b : times.on_b) + 12'h001);
        check(12'(phase), 12'({last_ph[2:0], last_ph[3]}));
      end
      model_ok = 1;
      run_len = 0;
      last_ph = phase;
    end
    // Outputs follow the on phases when inputs have no action
    if (mode_sel == 4'h0 || mode_sel > 4'ha)
      check(12'({wa, wb}), 12'({phase == PFM_ON_A, phase == PFM_ON_B}));
    run_len++;
  end

  // ****
  // Stimulus
  // ****
  initial
  begin
    repeat (8) @(negedge clk);
    arst_n = 1;
    check(12'({wa, wb, stalled, phase}), 12'(PFM_DEAD_A));
    // Random events and lengths in modes that keep the counter free, including undefined code 4'hd
    foreach (fm[i])
    begin
      setup(fm[i], 1);
      repeat (150)
      begin
        @(negedge clk);
        lfsr = lfsr_next(lfsr);
        if (lfsr[2:0] == 3'h0) req = pfm_ev_t'(lfsr[5:4]);
        if (lfsr[2:0] == 3'h0) slow = lfsr[6];
      end
    end
    slow = 0;
    scen(4'h1, EVA, PFM_ON_A, 4, PFM_DEAD_B, 1, PFM_DEAD_B);
    scen(4'h1, EVA, PFM_ON_B, 3, PFM_ON_B, 0, 0);
    scen(4'h2, EVA, PFM_ON_A, 4, PFM_DEAD_B, 0, PFM_ON_B);
    scen(4'h2, EVA, PFM_ON_A, 22, 0, 1, 0);
    scen(4'h2, 2'b01, PFM_ON_A, 3, PFM_ON_A, 0, 0);
    scen(4'h3, EVA, PFM_ON_A, 18, PFM_DEAD_B, 0, 0);
    scen(4'h5, EVA, PFM_ON_A, 12, PFM_DEAD_A, 0, PFM_ON_A);
    scen(4'h6, 2'b01, PFM_ON_A, 20, 0, 1, 0);
    scen(4'h6, EVA, PFM_DEAD_A, 3, PFM_DEAD_A, 0, 0);
    scen(4'h8, EVA, PFM_ON_A, 4, PFM_DEAD_B, 0, 0);
    scen(4'h8, EVA, PFM_ON_B, 3, PFM_ON_B, 0, 0);
    // Edge and level blocking keep output A off to the end of on time
    for (int m = 9; m <= 10; m++)
    begin
      setup(4'(m), 0);
      wait_ph(PFM_ON_A);
      req = EVA;
      repeat (3) @(negedge clk);
      check(12'({wa, phase}), 12'(PFM_ON_A));
      req = '0;
      repeat (2) @(negedge clk);
      check(12'(wa), 12'h000);
    end
    // Software halt and restart
    setup(4'h7, 0);
    wait_ph(PFM_ON_A);
    req = 2'b01;
    repeat (4) @(negedge clk);
    check(12'({stalled, wa, wb}), 12'h004);
    pulse();
    repeat (3) @(negedge clk);
    check(12'(stalled), 12'h001);
    req = '0;
    repeat (4) @(negedge clk);
    check(12'(stalled), 12'h001);
    pulse();
    repeat (3) @(negedge clk);
    check(12'({stalled, phase}), 12'(PFM_DEAD_A));
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #200us;
    err_count++;
    test_done();
  end
endmodule : pwm_fault_input_modes_test
